// ==== mcpc_pkg.sv ====
package mcpc_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  // cable_ready_after_power_time, in microseconds
  localparam int READY_TIME_US = 100000;
  // longest time rounds down, floor of at least one cycle
  localparam int READY_CYCLES_RAW = (READY_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int READY_CYCLES = (READY_CYCLES_RAW < 1) ? 1 : READY_CYCLES_RAW;

  // ------------------------------------------------------------
  // message addressing and commands
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MCPC_SOP = 2'h0,
    MCPC_SOP_P = 2'h1,
    MCPC_SOP_PP = 2'h2
  } mcpc_target_t;

  typedef enum logic [2:0] {
    MCPC_CMD_IDENTITY = 3'h1,
    MCPC_CMD_SVIDS = 3'h2,
    MCPC_CMD_MODES = 3'h3,
    MCPC_CMD_ENTER = 3'h4,
    MCPC_CMD_EXIT = 3'h5
  } mcpc_cmd_t;

  typedef enum logic [1:0] {
    MCPC_RSP_ACK = 2'h0,
    MCPC_RSP_NAK = 2'h1
  } mcpc_rsp_t;

  // arbitrary identity value, not tied to any maker
  localparam logic [31:0] ID_HEADER = 32'h0000_5a5a;
  // arbitrary supported svid and mode
  localparam logic [15:0] SVID_0 = 16'h1234;
  localparam logic [31:0] MODE_0 = 32'h0000_0001;
  localparam logic [2:0] MODE_INDEX_0 = 3'h1;

  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

endpackage

// ==== mcpc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// structured message link between a port controller and one cable plug
interface mcpc_if;
  logic reqValid;
  logic [1:0] reqTarget;
  logic [2:0] reqCmd;
  logic [15:0] reqSvid;
  logic [2:0] reqMode;
  logic rspValid;
  logic [1:0] rspKind;
  logic [31:0] rspData;

  modport plug (
    input reqValid, reqTarget, reqCmd, reqSvid, reqMode,
    output rspValid, rspKind, rspData
  );
  modport port (
    output reqValid, reqTarget, reqCmd, reqSvid, reqMode,
    input rspValid, rspKind, rspData
  );
endinterface
`default_nettype wire

// ==== mcpc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a pin level
module mcpc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== mcpc_plug.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - reset or Hard Reset: DFP SOP', UFP SOP''
// - after Cable Reset, VCONN plug is SOP'
// - role sensed from own VCONN pin
// - unassigned: ignore and never answer
// - ready within 100 ms of VCONN
// - two plugs get distinct roles
// - role held through all swaps
// - role kept until VCONN loss or Cable Reset; a Hard Reset also clears it and reassigns by end
// - cable messages never addressed to SOP
// - after contract only DFP addresses cable; the port also passes a non-DFP with bfskExempt set
// - discovery and mode commands start at SOP'
// - Discover SVIDs returns supported list
// - Discover Modes returns modes for SVID
// - Enter Mode enters requested mode
// - Exit Mode returns to default USB
// - DFP supplies VCONN on seeing Ra
module mcpc_plug import mcpc_pkg::*; #(
  parameter int READY_COUNT = READY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // plug pins
  input wire logic vconnPin,
  input wire logic atDfpEnd,
  // reset events from the port, one-cycle pulses
  input wire logic hardReset,
  input wire logic cableReset,
  // message link
  mcpc_if.plug link,
  // user side
  output logic [1:0] role,
  output logic modeActive,
  output logic [2:0] modeIndex
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // unassigned: no VCONN or just powered; wait: settling, deaf to the link;
  // assigned: role fixed and requests answered
  typedef enum logic [1:0] {ST_UNASSIGNED, ST_WAIT, ST_ASSIGNED} mcpc_phase_t;

  // everything the plug remembers, registered as one word
  typedef struct packed {
    mcpc_phase_t phase;
    logic [31:0] count;
    logic [1:0] role;
    logic byVconn;
    logic modeActive;
    logic [2:0] modeIndex;
    logic rspValid;
    logic [1:0] rspKind;
    logic [31:0] rspData;
  } mcpc_plug_state_t;

  // registered state and its next value
  mcpc_plug_state_t r;
  mcpc_plug_state_t next_r;
  // synchronised VCONN level and request match
  logic vconn;
  logic forMe;

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  // vconn arrives from the cable analog side; two flops keep a slow edge
  // from splitting the phase machine across two values
  mcpc_sync uVconn (
    .clk(clk),
    .nrst(nrst),
    .din(vconnPin),
    .dout(vconn)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // priority: power loss, then resets, then the phase machine; losing VCONN
  // must win over a reset pulse in the same cycle, or a dead plug could be
  // handed a role
  always_comb begin
    next_r = r;
    next_r.rspValid = 1'b0;
    forMe = link.reqValid && (link.reqTarget == r.role) && (r.role != MCPC_SOP);
    if (!vconn) begin
      // losing power clears phase, role, count and mode; byVconn and the last answer are kept
      next_r.phase = ST_UNASSIGNED;
      next_r.role = MCPC_SOP;
      next_r.count = '0;
      next_r.modeActive = 1'b0;
      next_r.modeIndex = '0;
    end else if (hardReset || cableReset) begin
      // cable reset selects by VCONN, hard reset by end
      next_r.phase = ST_WAIT;
      next_r.byVconn = cableReset;
      next_r.count = '0;
      next_r.modeActive = 1'b0;
      next_r.modeIndex = '0;
      next_r.role = MCPC_SOP;
    end else begin
      unique case (r.phase)
        ST_UNASSIGNED: begin
          // power-on: assign by end, cable ignores requests meanwhile
          // one settling pass even at power-on, so the end pin is stable
          next_r.phase = ST_WAIT;
          next_r.byVconn = 1'b0;
          next_r.count = '0;
        end
        ST_WAIT: begin
          // finishes well inside the ready interval
          // capped at eight cycles: far shorter than the port's hold-off
          if (r.count >= 32'(READY_COUNT - 1) || r.count >= 32'h7) begin
            next_r.phase = ST_ASSIGNED;
            // only the supplied plug sees VCONN, so roles differ
            if (r.byVconn) begin
              next_r.role = MCPC_SOP_P;
            end else begin
              next_r.role = atDfpEnd ? MCPC_SOP_P : MCPC_SOP_PP;
            end
          end else begin
            next_r.count = r.count + 32'h1;
          end
        end
        ST_ASSIGNED: begin
          // swaps are not seen here, role unchanged
          // one answer per request; the port keeps a single one outstanding
          if (forMe) begin
            next_r.rspValid = 1'b1;
            next_r.rspKind = MCPC_RSP_ACK;
            next_r.rspData = DATA_RESET;
            unique case (link.reqCmd)
              // fixed header; the svid list holds one entry
              MCPC_CMD_IDENTITY: next_r.rspData = ID_HEADER;
              MCPC_CMD_SVIDS: next_r.rspData = {SVID_0, 16'h0000};
              MCPC_CMD_MODES: begin
                // an unknown svid gets a refusal, not an empty list
                if (link.reqSvid == SVID_0) begin
                  next_r.rspData = MODE_0;
                end else begin
                  next_r.rspKind = MCPC_RSP_NAK;
                end
              end
              MCPC_CMD_ENTER: begin
                // only the one supported mode of the one svid is accepted
                if (link.reqSvid == SVID_0 && link.reqMode == MODE_INDEX_0) begin
                  next_r.modeActive = 1'b1;
                  next_r.modeIndex = link.reqMode;
                end else begin
                  next_r.rspKind = MCPC_RSP_NAK;
                end
              end
              MCPC_CMD_EXIT: begin
                if (r.modeActive) begin
                  next_r.modeActive = 1'b0;
                  next_r.modeIndex = '0;
                end else begin
                  next_r.rspKind = MCPC_RSP_NAK;
                end
              end
              // reserved command codes are refused
              default: next_r.rspKind = MCPC_RSP_NAK;
            endcase
          end
        end
        default: next_r.phase = ST_UNASSIGNED;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '{
        phase: ST_UNASSIGNED,
        count: 32'h0,
        role: MCPC_SOP,
        byVconn: 1'b0,
        modeActive: 1'b0,
        modeIndex: 3'h0,
        rspValid: 1'b0,
        rspKind: MCPC_RSP_ACK,
        rspData: DATA_RESET
      };
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // answer comes from flops, one cycle after the request it serves
  assign link.rspValid = r.rspValid;
  assign link.rspKind = r.rspKind;
  assign link.rspData = r.rspData;

  // role and mode straight from the state flops
  assign role = r.role;
  assign modeActive = r.modeActive;
  assign modeIndex = r.modeIndex;
endmodule
`default_nettype wire

// ==== mcpc_port.sv ====
`timescale 1ns/1ps
`default_nettype none
// port-controller end: forwards user requests to one cable plug
module mcpc_port import mcpc_pkg::*; #(
  parameter int READY_COUNT = READY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // port status
  input wire logic raSeen,
  input wire logic isDfp,
  input wire logic contract,
  input wire logic bfskExempt,
  // user request
  input wire logic userValid,
  input wire logic [1:0] userTarget,
  input wire logic [2:0] userCmd,
  input wire logic [15:0] userSvid,
  input wire logic [2:0] userMode,
  // link
  mcpc_if.port link,
  // user status
  output logic vconnOut,
  output logic cableReady,
  output logic userDone,
  output logic [1:0] userKind,
  output logic [31:0] userData
);
  typedef struct packed {
    logic vconn;
    logic [31:0] count;
    logic ready;
    logic identDone;
    logic busy;
    logic reqValid;
    logic [1:0] tgt;
    logic [2:0] cmd;
    logic [15:0] svid;
    logic [2:0] mode;
    logic done;
    logic [1:0] kind;
    logic [31:0] data;
  } mcpc_port_state_t;

  mcpc_port_state_t r;
  mcpc_port_state_t next_r;
  logic allowed;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.reqValid = 1'b0;
    next_r.done = 1'b0;
    next_r.vconn = raSeen && isDfp;
    allowed = (userTarget != MCPC_SOP)
      && (!contract || isDfp || bfskExempt)
      && (r.identDone || userTarget == MCPC_SOP_P);
    if (!r.vconn) begin
      next_r.count = '0;
      next_r.ready = 1'b0;
      next_r.identDone = 1'b0;
    end else if (!r.ready) begin
      // hold off the full ready interval
      if (r.count >= 32'(READY_COUNT - 1)) begin
        next_r.ready = 1'b1;
      end else begin
        next_r.count = r.count + 32'h1;
      end
    end
    if (r.busy && link.rspValid) begin
      next_r.busy = 1'b0;
      next_r.done = 1'b1;
      next_r.kind = link.rspKind;
      next_r.data = link.rspData;
      if (r.cmd == MCPC_CMD_IDENTITY && r.tgt == MCPC_SOP_P) begin
        next_r.identDone = 1'b1;
      end
    end else if (!r.busy && userValid && r.ready) begin
      if (allowed) begin
        next_r.busy = 1'b1;
        next_r.reqValid = 1'b1;
        next_r.tgt = userTarget;
        next_r.cmd = userCmd;
        next_r.svid = userSvid;
        next_r.mode = userMode;
      end else begin
        // refused locally, never sent
        next_r.done = 1'b1;
        next_r.kind = MCPC_RSP_NAK;
        next_r.data = DATA_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.reqValid = r.reqValid;
  assign link.reqTarget = r.tgt;
  assign link.reqCmd = r.cmd;
  assign link.reqSvid = r.svid;
  assign link.reqMode = r.mode;
  assign vconnOut = r.vconn;
  assign cableReady = r.ready;
  assign userDone = r.done;
  assign userKind = r.kind;
  assign userData = r.data;
endmodule
`default_nettype wire

// ==== mcpc_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// link checker
// --------
module mcpc_sva import mcpc_pkg::*; #(
  parameter int READY_COUNT = READY_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request side
  input wire logic reqValid,
  input wire logic [1:0] reqTarget,
  input wire logic [2:0] reqCmd,
  input wire logic [15:0] reqSvid,
  input wire logic [2:0] reqMode,
  // answer side
  input wire logic rspValid,
  input wire logic [1:0] rspKind,
  input wire logic [31:0] rspData
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic idSeen;
  int upCnt;
  // identity gate and time since reset; counter saturates so it stays small
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idSeen <= 1'b0;
      upCnt <= 0;
    end else begin
      if (rspValid && rspKind == MCPC_RSP_ACK && reqCmd == MCPC_CMD_IDENTITY) begin
        idSeen <= 1'b1;
      end
      if (upCnt < READY_COUNT) begin
        upCnt <= upCnt + 1;
      end
    end
  end
  // assertions
  a_no_sop_target: assert property (reqValid |-> reqTarget != MCPC_SOP)
    else $error("cable request addressed to plain port");
  a_first_at_prime: assert property (reqValid && !idSeen |-> reqTarget == MCPC_SOP_P)
    else $error("first request not at near plug");
  a_wait_ready: assert property (reqValid |-> upCnt >= READY_COUNT)
    else $error("request before ready interval");
  a_rsp_after_req: assert property (rspValid |-> $past(reqValid))
    else $error("answer without request");
  a_req_spacing: assert property (reqValid |=> !reqValid [*2])
    else $error("requests too close");
  a_prime_answers: assert property (reqValid && reqTarget == MCPC_SOP_P |=> rspValid)
    else $error("near plug did not answer");
  a_identity_data: assert property (rspValid && reqCmd == MCPC_CMD_IDENTITY |->
    rspKind == MCPC_RSP_ACK && rspData == ID_HEADER)
    else $error("identity answer wrong");
  a_svid_list: assert property (rspValid && reqCmd == MCPC_CMD_SVIDS |->
    rspKind == MCPC_RSP_ACK && rspData == {SVID_0, 16'h0000})
    else $error("svid list wrong");
  a_mode_list: assert property (rspValid && reqCmd == MCPC_CMD_MODES |->
    ((reqSvid != SVID_0) ? rspKind == MCPC_RSP_NAK
      : (rspKind == MCPC_RSP_ACK && rspData == MODE_0)))
    else $error("mode list wrong");
  a_enter_ack: assert property (rspValid && reqCmd == MCPC_CMD_ENTER && reqSvid == SVID_0
    && reqMode == MODE_INDEX_0 |-> rspKind == MCPC_RSP_ACK)
    else $error("supported mode refused");
  // main scenarios
  c_enter: cover property (rspValid && reqCmd == MCPC_CMD_ENTER && rspKind == MCPC_RSP_ACK);
  c_exit: cover property (rspValid && reqCmd == MCPC_CMD_EXIT && rspKind == MCPC_RSP_ACK);
  c_mode_nak: cover property (rspValid && reqCmd == MCPC_CMD_MODES && rspKind == MCPC_RSP_NAK);
endmodule
`default_nettype wire

// ==== mcpc_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// cable plug bench
// --------
module mcpc_tb import mcpc_pkg::*;;
  localparam int RC = 16;
  logic clk, nrst, vA, vB, hr, crA, crB, raSeen, isDfp, contract, bfsk, userValid;
  logic [1:0] userTarget, userKind, roleA, roleB;
  logic [2:0] userCmd, userMode, idxA, cmdR;
  logic [15:0] userSvid;
  logic [31:0] userData, r;
  logic vconnOut, cableReady, userDone, modeA, idOk, on;
  int fails, comparisons, n;
  mcpc_if lnkA();
  mcpc_if lnkB();
  mcpc_port #(.READY_COUNT(RC)) mcpc_port_i (.clk(clk), .nrst(nrst), .raSeen(raSeen),
    .isDfp(isDfp), .contract(contract), .bfskExempt(bfsk), .userValid(userValid),
    .userTarget(userTarget), .userCmd(userCmd), .userSvid(userSvid), .userMode(userMode),
    .link(lnkA), .vconnOut(vconnOut), .cableReady(cableReady), .userDone(userDone),
    .userKind(userKind), .userData(userData));
  mcpc_plug #(.READY_COUNT(RC)) mcpc_plug_i (.clk(clk), .nrst(nrst), .vconnPin(vA),
    .atDfpEnd(1'b1), .hardReset(hr), .cableReset(crA), .link(lnkA), .role(roleA),
    .modeActive(modeA), .modeIndex(idxA));
  // far plug: its link is driven by the bench alone
  mcpc_plug #(.READY_COUNT(RC)) mcpc_plug_ufp_i (.clk(clk), .nrst(nrst), .vconnPin(vB),
    .atDfpEnd(1'b0), .hardReset(hr), .cableReset(crB), .link(lnkB), .role(roleB),
    .modeActive(), .modeIndex());
  mcpc_sva #(.READY_COUNT(RC)) mcpc_sva_i (.clk(clk), .nrst(nrst), .reqValid(lnkA.reqValid),
    .reqTarget(lnkA.reqTarget), .reqCmd(lnkA.reqCmd), .reqSvid(lnkA.reqSvid),
    .reqMode(lnkA.reqMode), .rspValid(lnkA.rspValid), .rspKind(lnkA.rspKind),
    .rspData(lnkA.rspData));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // answer the rules predict from bench state: true for an accepted request
  function automatic logic exp_ok(input logic [1:0] t, input logic [2:0] c,
    input logic [15:0] s, input logic [2:0] m);
    logic ok;
    ok = (t == MCPC_SOP_P) || (t == MCPC_SOP_PP && idOk);
    ok = ok && !(contract && !isDfp && !bfsk);
    if (c == MCPC_CMD_MODES) ok = ok && s == SVID_0;
    if (c == MCPC_CMD_ENTER) ok = ok && s == SVID_0 && m == MODE_INDEX_0 && !on;
    if (c == MCPC_CMD_EXIT) ok = ok && on;
    if (c == 3'h0 || c > MCPC_CMD_EXIT) ok = 1'b0;
    return ok;
  endfunction
  // one request through the port; expectation from bench state, never from outputs
  task automatic send(input logic [1:0] t, input logic [2:0] c, input logic [15:0] s,
    input logic [2:0] m);
    logic ok;
    int w;
    ok = exp_ok(t, c, s, m);
    userValid = 1'b1;
    userTarget = t;
    userCmd = c;
    userSvid = s;
    userMode = m;
    tick(1);
    userValid = 1'b0;
    w = 0;
    while (userDone !== 1'b1 && w < 10) begin
      tick(1);
      w++;
    end
    if (w >= 10) begin
      fails++;
      end_sim();
    end
    chk("userKind", userKind, ok ? MCPC_RSP_ACK : MCPC_RSP_NAK);
    if (ok && c == MCPC_CMD_IDENTITY) chk("identity", userData, ID_HEADER);
    if (ok && c == MCPC_CMD_SVIDS) chk("svids", userData, {SVID_0, 16'h0000});
    if (ok && c == MCPC_CMD_MODES) chk("modes", userData, MODE_0);
    if (ok && c == MCPC_CMD_IDENTITY) idOk = 1'b1;
    if (ok && c == MCPC_CMD_ENTER) on = 1'b1;
    if (ok && c == MCPC_CMD_EXIT) on = 1'b0;
    tick(2);
    chk("modeActive", modeA, on);
    if (on) chk("modeIndex", idxA, MODE_INDEX_0);
  endtask
  // one-cycle request straight into the far plug
  task automatic poke(input logic [1:0] t, input logic exp);
    lnkB.reqValid = 1'b1;
    lnkB.reqTarget = t;
    tick(1);
    lnkB.reqValid = 1'b0;
    chk("farRsp", lnkB.rspValid, exp);
    tick(1);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {nrst, hr, crA, crB, contract, bfsk, userValid, userTarget, userCmd, userSvid, userMode} = '0;
    {vA, vB, raSeen, isDfp} = 4'hf;
    {lnkB.reqValid, lnkB.reqTarget, lnkB.reqSvid, lnkB.reqMode} = '0;
    lnkB.reqCmd = MCPC_CMD_IDENTITY;
    {fails, comparisons, idOk, on} = '0;
    r = 32'h18ec2536;
    tick(16);
    nrst = 1'b1;
    n = 0;
    while (cableReady !== 1'b1 && n < RC + 20) begin
      tick(1);
      n++;
    end
    chk("cableReady", cableReady, 1'b1);
    if (cableReady !== 1'b1) end_sim();
    chk("vconnOut", vconnOut, 1'b1);
    chk("roleA", roleA, MCPC_SOP_P);
    chk("roleB", roleB, MCPC_SOP_PP);
    // refusals around the first identity, then mode entry, exit and random traffic
    send(MCPC_SOP_PP, MCPC_CMD_SVIDS, SVID_0, 3'h0);
    send(MCPC_SOP, MCPC_CMD_IDENTITY, SVID_0, 3'h0);
    send(MCPC_SOP_P, MCPC_CMD_EXIT, SVID_0, MODE_INDEX_0);
    send(MCPC_SOP_P, MCPC_CMD_IDENTITY, SVID_0, 3'h0);
    send(MCPC_SOP_P, 3'h7, SVID_0, 3'h0);
    send(MCPC_SOP, MCPC_CMD_SVIDS, SVID_0, 3'h0);
    send(MCPC_SOP_P, MCPC_CMD_ENTER, SVID_0, MODE_INDEX_0);
    send(MCPC_SOP_P, MCPC_CMD_EXIT, SVID_0, MODE_INDEX_0);
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      cmdR = (r[2:0] % 3'h5) + 3'h1;
      if (cmdR == MCPC_CMD_ENTER && on) cmdR = MCPC_CMD_EXIT;
      send(MCPC_SOP_P, cmdR, r[8] ? SVID_0 : r[31:16], r[9] ? MODE_INDEX_0 : r[12:10]);
    end
    if (on) send(MCPC_SOP_P, MCPC_CMD_EXIT, SVID_0, MODE_INDEX_0);
    // resets and power loss on the plugs
    hr = 1'b1;
    tick(1);
    hr = 1'b0;
    tick(20);
    chk("roleA", roleA, MCPC_SOP_P);
    chk("roleB", roleB, MCPC_SOP_PP);
    crA = 1'b1;
    tick(1);
    crA = 1'b0;
    tick(20);
    chk("roleA", roleA, MCPC_SOP_P);
    poke(MCPC_SOP_P, 1'b0);
    poke(MCPC_SOP_PP, 1'b1);
    vB = 1'b0;
    tick(20);
    chk("roleB", roleB, 2'h0);
    poke(MCPC_SOP_PP, 1'b0);
    // VCONN only at the far end, then a cable reset there: far plug turns SOP'
    vA = 1'b0;
    vB = 1'b1;
    tick(20);
    chk("roleB", roleB, MCPC_SOP_PP);
    crB = 1'b1;
    tick(1);
    crB = 1'b0;
    tick(20);
    chk("roleB", roleB, MCPC_SOP_P);
    chk("roleA", roleA, 2'h0);
    poke(MCPC_SOP_P, 1'b1);
    vA = 1'b1;
    tick(20);
    // contract: the downstream end may still talk; a non-DFP end is refused
    // in the cycle VCONN drops the port still counts as ready
    contract = 1'b1;
    send(MCPC_SOP_P, MCPC_CMD_IDENTITY, SVID_0, 3'h0);
    isDfp = 1'b0;
    send(MCPC_SOP_P, MCPC_CMD_IDENTITY, SVID_0, 3'h0);
    tick(3);
    chk("vconnOut", vconnOut, 1'b0);
    chk("cableReady", cableReady, 1'b0);
    // power again, count the hold-off, then the exempt non-DFP request goes through
    isDfp = 1'b1;
    n = 0;
    while (cableReady !== 1'b1 && n < RC + 20) begin
      tick(1);
      n++;
    end
    chk("cableReady", cableReady, 1'b1);
    if (cableReady !== 1'b1) end_sim();
    chk("readyWait", 32'(n >= RC), 32'h1);
    bfsk = 1'b1;
    isDfp = 1'b0;
    send(MCPC_SOP_P, MCPC_CMD_IDENTITY, SVID_0, 3'h0);
    end_sim();
  end
endmodule
`default_nettype wire
